/* src/rcsc_pkg.sv */
// package for the reset and clock source control block
// assumes a single 10 MHz clock and software access over classic wishbone
package rcsc_pkg;
  // ----------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] RCSC_ADDR_MASK   = 8'h00; // reset source disables
  localparam logic [7:0] RCSC_ADDR_CAUSE  = 8'h04; // last reset cause
  localparam logic [7:0] RCSC_ADDR_WDOG   = 8'h08; // watchdog control
  localparam logic [7:0] RCSC_ADDR_CLKSEL = 8'h0C; // clock source select
  localparam logic [7:0] RCSC_ADDR_SWRST  = 8'h10; // software reset trigger
  // ----------------------------------------------------------------------
  // reset source bit positions
  // ----------------------------------------------------------------------
  localparam int RCSC_NSRC    = 7;
  localparam int RCSC_SRC_SUP = 0; // supply monitor, never maskable
  localparam int RCSC_SRC_WDG = 1; // watchdog timeout
  localparam int RCSC_SRC_MCD = 2; // missing clock detector
  localparam int RCSC_SRC_CMP = 3; // comparator level detect
  localparam int RCSC_SRC_SW  = 4; // software forced
  localparam int RCSC_SRC_CNV = 5; // conversion start pin
  localparam int RCSC_SRC_PIN = 6; // external reset pin, never maskable
  // maskable sources only; supply and pin bits are forced zero
  localparam logic [6:0] RCSC_MASKABLE = 7'h3E;
  // ----------------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [6:0] RCSC_MASK_RST   = 7'h00;
  localparam logic [6:0] RCSC_CAUSE_RST  = 7'h01; // power-on shows supply
  localparam int         RCSC_WDOG_EN    = 0;
  localparam int         RCSC_WDOG_LOCK  = 1;
  localparam int         RCSC_CLK_EXT    = 0;
  localparam int         RCSC_CLK_ACTIVE = 1;
  localparam logic [1:0] RCSC_WDOG_RST   = 2'h1; // enabled, unlocked
  localparam logic [3:0] RCSC_HOLD_CYC   = 4'h8; // release stretch
  localparam int         RCSC_CLK_MHZ    = 10;
  localparam int         RCSC_INT_OSC_MAX_MHZ = 16;
  // ----------------------------------------------------------------------
  // wishbone request carrier
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } rcsc_wb_req_t;
endpackage

/* src/rcsc_top.sv */
// reset gathering, watchdog lock and system clock source selection
// assumes pins are synchronous to MCLK_IN; wishbone master honours classic cycles
// ----------------------------------------------------------------------
// behaviour notes
// ----------------------------------------------------------------------
// - every source is a level; a short glitch on any source not disabled is enough to
//   start a full stretch, since the counter reloads on each active cycle
// - the reset pin is ignored as a source while this block drives it low,
//   otherwise the power-on drive would feed back and never end
// - the pin is driven only in the power-on phase; other resets leave it
//   released so that the board sees only genuine power-on events
// - the cause register keeps the first source seen while the system
//   reset is high; sources that arrive during the stretch do not count
// - the watchdog lock is cleared by any system reset, not only power-on;
//   software is expected to set it again early in its start-up code
// - the clock select only steers the downstream clock switch; glitch-free
//   switching between the oscillators is the job of that switch
// - register writes during a system reset are dropped, because the reset
//   branch of the software state wins over the bus
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module rcsc_top
  import rcsc_pkg::*;
#(
  parameter logic [3:0] HOLD_CYC = RCSC_HOLD_CYC
) (
  // clock and reset
  input  wire logic               MCLK_IN,
  input  wire logic               RESET_N_IN,
  // reset sources
  input  wire logic               SUPPLY_LOW_IN,
  input  wire logic               WDOG_TIMEOUT_IN,
  input  wire logic               CLK_MISSING_IN,
  input  wire logic               CMP_LEVEL_IN,
  input  wire logic               CONV_START_IN,
  // bidirectional reset pin
  input  wire logic               RST_PIN_N_IN,
  output logic                    RST_PIN_N_OUT,
  output logic                    RST_PIN_OE_OUT,
  // wishbone slave
  input  wire rcsc_pkg::rcsc_wb_req_t WB_REQ_IN,
  output logic [31:0]             WB_DAT_OUT,
  output logic                    WB_ACK_OUT,
  // system outputs
  output logic                    SYS_RST_N_OUT,
  output logic                    WDOG_EN_OUT,
  output logic                    CLK_EXT_SEL_OUT
);
  import rcsc_pkg::*;
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [6:0]  mask_r, mask_nxt;      // source disables
  logic [6:0]  cause_r, cause_nxt;    // latched cause of last reset
  logic        wdog_en_r, wdog_en_nxt;
  logic        wdog_lock_r, wdog_lock_nxt;
  logic        clk_ext_r, clk_ext_nxt;
  logic        sw_rst_r, sw_rst_nxt;  // one-cycle software reset request
  logic        por_r;                 // power-on phase flag
  logic [3:0]  hold_r, hold_nxt;      // release stretch counter
  logic        sys_rst_n_r;
  logic        ack_r;
  logic [31:0] rdat_r, rdat_nxt;
  logic        pin_oe_r;              // reset pin drive enable
  logic [3:0]  quiet_r;               // checker helper: quiet cycles, saturating
  // ----------------------------------------------------------------------
  // source gathering
  // ----------------------------------------------------------------------
  // own drive of the pin must not count as an outside request
  wire logic [6:0] src_raw = {~RST_PIN_N_IN & ~pin_oe_r, CONV_START_IN, sw_rst_r, CMP_LEVEL_IN,
                              CLK_MISSING_IN, WDOG_TIMEOUT_IN & wdog_en_r,
                              SUPPLY_LOW_IN};
  // masking never reaches supply and pin bits
  wire logic [6:0] src_act = src_raw & ~(mask_r & RCSC_MASKABLE);
  wire logic       any_src = |src_act;
  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire logic       wb_hit  = WB_REQ_IN.cyc & WB_REQ_IN.stb & ~ack_r;
  wire logic       wb_wr   = wb_hit & WB_REQ_IN.we & WB_REQ_IN.sel[0];
  wire logic       sel_msk = WB_REQ_IN.adr == RCSC_ADDR_MASK;
  wire logic       sel_cau = WB_REQ_IN.adr == RCSC_ADDR_CAUSE;
  wire logic       sel_wdg = WB_REQ_IN.adr == RCSC_ADDR_WDOG;
  wire logic       sel_clk = WB_REQ_IN.adr == RCSC_ADDR_CLKSEL;
  wire logic       sel_sw  = WB_REQ_IN.adr == RCSC_ADDR_SWRST;
  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    mask_nxt      = mask_r;
    wdog_lock_nxt = wdog_lock_r;
    wdog_en_nxt   = wdog_en_r;
    clk_ext_nxt   = clk_ext_r;
    sw_rst_nxt    = 1'b0;
    cause_nxt     = cause_r;
    rdat_nxt      = 32'h0000_0000;
    if (wb_wr && sel_msk) begin
      mask_nxt = WB_REQ_IN.dat[6:0] & RCSC_MASKABLE;
    end
    if (wb_wr && sel_wdg) begin
      // lock is sticky; once set the enable cannot be cleared
      wdog_lock_nxt = wdog_lock_r | WB_REQ_IN.dat[RCSC_WDOG_LOCK];
      wdog_en_nxt   = WB_REQ_IN.dat[RCSC_WDOG_EN] | wdog_lock_nxt;
    end
    if (wb_wr && sel_clk) begin
      clk_ext_nxt = WB_REQ_IN.dat[RCSC_CLK_EXT];
    end
    if (wb_wr && sel_sw) begin
      sw_rst_nxt = WB_REQ_IN.dat[0];
    end
    // a new source overwrites the cause only while no reset is in hold
    if (any_src && sys_rst_n_r) begin
      cause_nxt = src_act;
    end
    case (1'b1)
      sel_msk: rdat_nxt[6:0] = mask_r;
      sel_cau: rdat_nxt[6:0] = cause_r;
      sel_wdg: rdat_nxt[1:0] = {wdog_lock_r, wdog_en_r};
      sel_clk: rdat_nxt[1:0] = {clk_ext_r, clk_ext_r};
      default: rdat_nxt      = 32'h0000_0000;
    endcase
  end
  // stretch counter reloads while any source is active
  always_comb begin
    if (any_src) begin
      hold_nxt = HOLD_CYC;
    end else if (hold_r != 4'h0) begin
      hold_nxt = hold_r - 4'h1;
    end else begin
      hold_nxt = hold_r;
    end
  end
  // ----------------------------------------------------------------------
  // reset sequencer, cleared only by the power-on reset
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      hold_r      <= HOLD_CYC;
      sys_rst_n_r <= 1'b0;
      por_r       <= 1'b1;
      cause_r     <= RCSC_CAUSE_RST;
    end else begin
      hold_r      <= hold_nxt;
      sys_rst_n_r <= (hold_nxt == 4'h0);
      por_r       <= por_r & ~(hold_nxt == 4'h0);
      cause_r     <= cause_nxt;
    end
  end
  // ----------------------------------------------------------------------
  // software-visible state, also cleared by system reset
  // ----------------------------------------------------------------------
  // lock survives only until the next system reset; any system reset drops it
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mask_r      <= RCSC_MASK_RST;
      wdog_en_r   <= RCSC_WDOG_RST[RCSC_WDOG_EN];
      wdog_lock_r <= RCSC_WDOG_RST[RCSC_WDOG_LOCK];
      clk_ext_r   <= 1'b0;
      sw_rst_r    <= 1'b0;
    end else if (!sys_rst_n_r) begin
      mask_r      <= RCSC_MASK_RST;
      wdog_en_r   <= RCSC_WDOG_RST[RCSC_WDOG_EN];
      wdog_lock_r <= RCSC_WDOG_RST[RCSC_WDOG_LOCK];
      clk_ext_r   <= 1'b0;
      sw_rst_r    <= 1'b0;
    end else begin
      mask_r      <= mask_nxt;
      wdog_en_r   <= wdog_en_nxt;
      wdog_lock_r <= wdog_lock_nxt;
      clk_ext_r   <= clk_ext_nxt;
      sw_rst_r    <= sw_rst_nxt;
    end
  end
  // ----------------------------------------------------------------------
  // bus answer, one wait-free cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= wb_hit;
      rdat_r <= rdat_nxt;
    end
  end
  // ----------------------------------------------------------------------
  // pin drive: active only in power-on phase, low while driven
  // ----------------------------------------------------------------------
  // enable follows the power-on flag, so the pin lets go at the same edge
  // at which the system reset is released
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pin_oe_r <= 1'b1;
    end else begin
      pin_oe_r <= por_r & ~(hold_nxt == 4'h0);
    end
  end
  assign RST_PIN_N_OUT   = 1'b0;
  assign RST_PIN_OE_OUT  = pin_oe_r;
  assign SYS_RST_N_OUT   = sys_rst_n_r;
  assign WDOG_EN_OUT     = wdog_en_r;
  assign CLK_EXT_SEL_OUT = clk_ext_r;
  assign WB_ACK_OUT      = ack_r;
  assign WB_DAT_OUT      = rdat_r;
  // ----------------------------------------------------------------------
  // checker helper: cycles since the last active source
  // ----------------------------------------------------------------------
  // counted apart from the stretch counter so that the release checks do
  // not lean on the logic that they watch; saturates at the hold length
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      quiet_r <= 4'h0;
    end else if (any_src) begin
      quiet_r <= 4'h0;
    end else if (quiet_r < HOLD_CYC) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  unmask_supply_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    SUPPLY_LOW_IN |=> !SYS_RST_N_OUT) else $error("supply low did not reset");
  unmask_pin_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !RST_PIN_N_IN && !RST_PIN_OE_OUT |=> !SYS_RST_N_OUT)
    else $error("reset pin did not reset");
  src_reset_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    any_src |=> !SYS_RST_N_OUT) else $error("active source without reset");
  hold_stretch_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    quiet_r < HOLD_CYC |-> !SYS_RST_N_OUT) else $error("release too early");
  release_bound_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    quiet_r >= HOLD_CYC |-> SYS_RST_N_OUT) else $error("release too late");
  mask_fixed_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (mask_r & ~RCSC_MASKABLE) == 7'h00) else $error("unmaskable source disabled");
  pin_por_only_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !por_r |-> !RST_PIN_OE_OUT) else $error("pin driven after power-on");
  lock_sticky_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    wdog_lock_r && SYS_RST_N_OUT |=> wdog_lock_r) else $error("lock dropped");
  sw_reset_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    wb_wr && sel_sw && WB_REQ_IN.dat[0] && SYS_RST_N_OUT && !mask_r[RCSC_SRC_SW]
    |=> ##1 !SYS_RST_N_OUT) else $error("software reset not taken");
  wb_answer_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    wb_hit |=> WB_ACK_OUT) else $error("bus request not answered");
  wb_ack_pulse_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack longer than one cycle");
  wdog_locked_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    wdog_lock_r && SYS_RST_N_OUT |-> WDOG_EN_OUT) else $error("locked watchdog off");
  clk_int_rst_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !SYS_RST_N_OUT |=> !CLK_EXT_SEL_OUT) else $error("external clock after reset");
  clk_switch_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    wb_wr && sel_clk && SYS_RST_N_OUT |=> CLK_EXT_SEL_OUT == $past(WB_REQ_IN.dat[0]))
    else $error("clock select not applied");
  pin_drive_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    RST_PIN_OE_OUT |-> !SYS_RST_N_OUT) else $error("pin driven outside reset");
endmodule

/* verification/rcsc_board.sv */
// board model of the reset pin: pull-up and an outside reset pusher
// assumes the design drives its pin value only while its enable is high
`timescale 1ns/10ps
module rcsc_board (
  // design side
  input  wire logic pin_oe_in,
  input  wire logic pin_val_in,
  // board side
  input  wire logic ext_low_in,
  output logic      pin_lvl_out
);
  // wired low with pull-up: a released pin reads high, never the last value
  assign pin_lvl_out = !((pin_oe_in && !pin_val_in) || ext_low_in);
endmodule

/* verification/rcsc_top_tb.sv */
// self-checking bench for reset gathering, watchdog lock and clock select
// assumes rcsc_top with one clock and a classic wishbone slave
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: value differs", $time); end end
module rcsc_top_tb;
  import rcsc_pkg::*;
  localparam logic [3:0] HOLD = 4'h4; // shortened stretch keeps the run short
  logic         mclk  = 1'b0;  // 10 MHz bench clock
  logic         rst_n = 1'b0;  // power-on reset
  logic [6:0]   src   = 7'h00; // source requests, pin bit goes to the board
  rcsc_wb_req_t wb    = '0;    // wishbone request
  logic         pin_lvl, pin_val, pin_oe, sys_rst_n, wdog_en, clk_ext, ack;
  logic [31:0]  rdat, d;
  int           miscompares  = 0;
  int           total_checks = 0;
  // clock generator
  always #50 mclk = ~mclk;
  rcsc_board board (.pin_oe_in(pin_oe), .pin_val_in(pin_val), .ext_low_in(src[RCSC_SRC_PIN]),
    .pin_lvl_out(pin_lvl));
  rcsc_top #(.HOLD_CYC(HOLD)) uut (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .SUPPLY_LOW_IN(src[0]),
    .WDOG_TIMEOUT_IN(src[1]), .CLK_MISSING_IN(src[2]), .CMP_LEVEL_IN(src[3]),
    .CONV_START_IN(src[5]), .RST_PIN_N_IN(pin_lvl), .RST_PIN_N_OUT(pin_val),
    .RST_PIN_OE_OUT(pin_oe), .WB_REQ_IN(wb), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .SYS_RST_N_OUT(sys_rst_n), .WDOG_EN_OUT(wdog_en), .CLK_EXT_SEL_OUT(clk_ext));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  // single place where the run ends
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a bounded wait that ran out is a mismatch
  task automatic timed_out();
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    print_verdict();
  endtask
  // classic cycle: hold everything until the edge that samples ack
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    int i;
    @(posedge mclk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (ack === 1'b1) break;
    end
    if (i == 20) timed_out();
    rd = rdat;
    wb <= '0;
    @(posedge mclk);
  endtask
  // raise one source; if it should reset, measure the stretch and the cause
  task automatic pulse_src(input int s, input logic hit);
    int i;
    int n;
    if (s == RCSC_SRC_SW) begin
      wb_xfer(1'b1, RCSC_ADDR_SWRST, 32'h1, d);
    end else begin
      @(posedge mclk);
      src[s] <= 1'b1;
    end
    for (i = 0; i < 5 && sys_rst_n === 1'b1; i++) @(posedge mclk);
    src <= 7'h00;
    `CHK(sys_rst_n, !hit)
    if (hit) begin
      for (n = 0; n < 50 && sys_rst_n !== 1'b1; n++) @(posedge mclk);
      `CHK(n >= HOLD - 1 && n <= HOLD + 2, 1'b1)
      `CHK(pin_oe, 1'b0)
      `CHK(clk_ext, 1'b0)
      wb_xfer(1'b0, RCSC_ADDR_CAUSE, 32'h0, d);
      `CHK(d[s], 1'b1)
    end
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int s;
    int i;
    repeat (20) @(posedge mclk);
    `CHK(pin_oe, 1'b1)
    `CHK(pin_lvl, 1'b0)
    rst_n <= 1'b1;
    for (i = 0; i < 30 && sys_rst_n !== 1'b1; i++) @(posedge mclk);
    if (i == 30) timed_out();
    `CHK(pin_oe, 1'b0)
    `CHK(pin_lvl, 1'b1)
    `CHK(clk_ext, 1'b0)
    wb_xfer(1'b0, RCSC_ADDR_CAUSE, 32'h0, d);
    `CHK(d[6:0], RCSC_CAUSE_RST)
    wb_xfer(1'b0, RCSC_ADDR_WDOG, 32'h0, d);
    `CHK(d[1:0], RCSC_WDOG_RST)
    $display("test power-on done");
    for (s = 0; s < RCSC_NSRC; s++) pulse_src(s, 1'b1);
    $display("test all sources done");
    // disable all that can be disabled, then try every source
    for (s = 0; s < RCSC_NSRC; s++) begin
      wb_xfer(1'b1, RCSC_ADDR_MASK, 32'h7F, d);
      wb_xfer(1'b0, RCSC_ADDR_MASK, 32'h0, d);
      `CHK(d[6:0], RCSC_MASKABLE)
      pulse_src(s, s == RCSC_SRC_SUP || s == RCSC_SRC_PIN);
    end
    $display("test disables done");
    // lock cannot be undone by software; a reset frees it
    wb_xfer(1'b1, RCSC_ADDR_WDOG, 32'h2, d);
    wb_xfer(1'b0, RCSC_ADDR_WDOG, 32'h0, d);
    `CHK(d[1:0], 2'h3)
    wb_xfer(1'b1, RCSC_ADDR_WDOG, 32'h0, d);
    `CHK(wdog_en, 1'b1)
    pulse_src(RCSC_SRC_WDG, 1'b1);
    wb_xfer(1'b1, RCSC_ADDR_WDOG, 32'h0, d);
    `CHK(wdog_en, 1'b0)
    pulse_src(RCSC_SRC_WDG, 1'b0);
    $display("test watchdog lock done");
    // switch on the fly both ways, then a reset returns to internal
    wb_xfer(1'b1, RCSC_ADDR_CLKSEL, 32'h1, d);
    `CHK(clk_ext, 1'b1)
    wb_xfer(1'b0, RCSC_ADDR_CLKSEL, 32'h0, d);
    `CHK(d[1:0], 2'h3)
    wb_xfer(1'b1, RCSC_ADDR_CLKSEL, 32'h0, d);
    `CHK(clk_ext, 1'b0)
    wb_xfer(1'b1, RCSC_ADDR_CLKSEL, 32'h1, d);
    pulse_src(RCSC_SRC_CMP, 1'b1);
    wb_xfer(1'b0, 8'h20, 32'h0, d);
    `CHK(d, 32'h0)
    $display("test clock select done");
    print_verdict();
  end
endmodule
